/* File: tarp_pkg.sv */
/*
 * Shared constants for the thermal alarm register port: register command
 * offsets, reset values, flag positions, serial framing counts and the
 * slave state enumeration.
 * Assumes every user imports the whole package.
 */
package tarp_pkg;

    // ------------------------------------------------------------------
    // Register command offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_REMOTE_TEMP = 8'h00;
    localparam logic [7:0] OFS_LOCAL_TEMP = 8'h01;
    localparam logic [7:0] OFS_SETUP = 8'h02;
    localparam logic [7:0] OFS_REMOTE_LIMIT = 8'h03;
    localparam logic [7:0] OFS_LOCAL_LIMIT = 8'h04;
    localparam logic [7:0] OFS_ALARM_FLAGS = 8'h05;
    localparam logic [7:0] OFS_ALARM_MASK = 8'h06;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] RST_SETUP = 8'h00;
    localparam logic [7:0] RST_REMOTE_LIMIT = 8'h6E;
    localparam logic [7:0] RST_LOCAL_LIMIT = 8'h50;
    localparam logic [1:0] RST_FLAGS = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h0;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Flag and mask layout: bit 7 remote, bit 6 local, rest read zero
    // ------------------------------------------------------------------
    localparam int FLAG_HI = 7;
    localparam int FLAG_LO = 6;
    localparam int CH_REMOTE = 1;
    localparam int CH_LOCAL = 0;
    localparam int N_CH = 2;
    localparam logic [5:0] FLAG_PAD = 6'h00;

    // ------------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------------
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [3:0] BIT_LAST_OUT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } tarp_state_e;

endpackage

/* File: tarp_sync.sv */
/*
 * Two-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes the inputs are independent levels; no bus coherency is implied.
 */
`timescale 1ns/10ps
module tarp_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // Inputs idle high on an open-drain bus, so reset to one.
    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    meta_reg[i] <= 1'b1;
                    q[i] <= 1'b1;
                end else begin
                    meta_reg[i] <= d[i];
                    q[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule

/* File: tarp_alarm.sv */
/*
 * Over-temperature compare, sticky alarm flags and the open-drain alarm
 * enable for the remote and local channels.
 * Assumes meas_done is a one-cycle pulse on clk carrying fresh readings,
 * and status_read is a one-cycle pulse when the flag byte is sent.
 */
`timescale 1ns/10ps
module tarp_alarm
    import tarp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic meas_done,
    input wire logic [15:0] meas,
    input wire logic [15:0] limit,
    input wire logic [1:0] mask,
    input wire logic status_read,
    output logic [1:0] flags,
    output logic alarm_oe
);

    logic [1:0] over;
    logic [1:0] trip;

    // --------------------------------------------------------------------
    // Per-channel compare and sticky flag
    // --------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N_CH; i++) begin : g_ch
            assign over[i] = meas[i*8 +: 8] > limit[i*8 +: 8];
            assign trip[i] = meas_done && over[i];

            // A trip in the same cycle as a clearing read wins.
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    flags[i] <= RST_FLAGS[i];
                end else if (trip[i]) begin
                    flags[i] <= 1'b1;
                end else if (status_read) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------------
    // Alarm pin enable
    // --------------------------------------------------------------------
    // The pin stays latched low until the flags are read, even if the
    // temperature drops back, so a short excursion is never missed.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alarm_oe <= 1'b0;
        end else if (|(trip & ~mask)) begin
            alarm_oe <= 1'b1;
        end else if (status_read) begin
            alarm_oe <= 1'b0;
        end
    end

    chk_alarm_assert: assert property (@(posedge clk)
        disable iff (!resetn)
        meas_done && |(over & ~mask) |=> alarm_oe)
        else $error("Alarm not driven after unmasked over-limit reading.");

    chk_mask_blocks: assert property (@(posedge clk)
        disable iff (!resetn)
        !alarm_oe && meas_done && ((over & ~mask) == 2'h0) |=> !alarm_oe)
        else $error("Masked or clear channel drove the alarm.");

    chk_flag_sets: assert property (@(posedge clk)
        disable iff (!resetn)
        meas_done && over[CH_REMOTE] |=> flags[CH_REMOTE])
        else $error("Remote flag not set after over-limit reading.");

    chk_read_clears: assert property (@(posedge clk)
        disable iff (!resetn)
        status_read && !meas_done |=> flags == 2'h0 && !alarm_oe)
        else $error("Status read did not clear flags and release alarm.");

    chk_flag_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !status_read && !meas_done |=> $stable(flags))
        else $error("Alarm flags changed without a read or measurement.");

endmodule

/* File: tarp_top.sv */
/*
 * Two-wire serial register port with over-temperature alarm: slave
 * receiver/transmitter, register bank and alarm wiring.
 * Assumes the bus pins are open drain with external pull-ups, that the
 * measurement engine delivers readings with a one-cycle meas_done pulse
 * on clk, and that the fan logic consumes setup_out.
 */
`timescale 1ns/10ps
module tarp_top
    import tarp_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic meas_done,
    input wire logic [7:0] remote_meas,
    input wire logic [7:0] local_meas,
    output logic overheat_alarm_n_out,
    output logic overheat_alarm_n_oe,
    output logic [7:0] setup_out
);

    // ------------------------------------------------------------------
    // Pin synchronisation and bus conditions
    // ------------------------------------------------------------------
    logic [1:0] pin_sync;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    tarp_sync #(.W(2)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({scl_in, sda_in}),
        .q(pin_sync)
    );

    assign scl_s = pin_sync[1];
    assign sda_s = pin_sync[0];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign bus_start = scl_s && scl_d && sda_d && !sda_s;
    assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    logic [7:0] remote_temp_reading_reg;
    logic [7:0] local_temp_reading_reg;
    logic [7:0] setup_byte_reg;
    logic [7:0] remote_alarm_limit_reg;
    logic [7:0] local_alarm_limit_reg;
    logic [1:0] alarm_mask_reg;
    logic [1:0] alarm_flags;
    logic alarm_oe;

    tarp_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] pointer_reg;
    logic rw_reg;
    logic nack_reg;
    logic wr_en;
    logic load_rd;
    logic status_read;
    logic [7:0] rd_data;

    // Readings are unsigned whole degrees, bit 7 worth 128 C.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            remote_temp_reading_reg <= RST_TEMP;
            local_temp_reading_reg <= RST_TEMP;
        end else if (meas_done) begin
            remote_temp_reading_reg <= remote_meas;
            local_temp_reading_reg <= local_meas;
        end
    end

    assign wr_en = (state_reg == ST_WDATA) && scl_fall
        && (bit_cnt_reg == BYTE_BITS);

    // Read-only offsets, including the flags, ignore writes.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            setup_byte_reg <= RST_SETUP;
            remote_alarm_limit_reg <= RST_REMOTE_LIMIT;
            local_alarm_limit_reg <= RST_LOCAL_LIMIT;
            alarm_mask_reg <= RST_MASK;
        end else if (wr_en) begin
            case (pointer_reg)
                OFS_SETUP: setup_byte_reg <= shift_reg;
                OFS_REMOTE_LIMIT: remote_alarm_limit_reg <= shift_reg;
                OFS_LOCAL_LIMIT: local_alarm_limit_reg <= shift_reg;
                OFS_ALARM_MASK: begin
                    alarm_mask_reg <= shift_reg[FLAG_HI:FLAG_LO];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (pointer_reg)
            OFS_REMOTE_TEMP: rd_data = remote_temp_reading_reg;
            OFS_LOCAL_TEMP: rd_data = local_temp_reading_reg;
            OFS_SETUP: rd_data = setup_byte_reg;
            OFS_REMOTE_LIMIT: rd_data = remote_alarm_limit_reg;
            OFS_LOCAL_LIMIT: rd_data = local_alarm_limit_reg;
            OFS_ALARM_FLAGS: rd_data = {alarm_flags, FLAG_PAD};
            OFS_ALARM_MASK: rd_data = {alarm_mask_reg, FLAG_PAD};
            default: rd_data = RD_UNMAPPED;
        endcase
    end

    // ------------------------------------------------------------------
    // Alarm
    // ------------------------------------------------------------------
    // The flags are cleared the moment their byte is loaded for sending,
    // so an aborted read still counts as a read.
    assign load_rd = scl_fall
        && (((state_reg == ST_ADDR_ACK) && rw_reg)
        || ((state_reg == ST_RDATA_ACK) && !nack_reg));
    assign status_read = load_rd && (pointer_reg == OFS_ALARM_FLAGS);

    tarp_alarm u_alarm (
        .clk(clk),
        .resetn(resetn),
        .meas_done(meas_done),
        .meas({remote_meas, local_meas}),
        .limit({remote_alarm_limit_reg, local_alarm_limit_reg}),
        .mask(alarm_mask_reg),
        .status_read(status_read),
        .flags(alarm_flags),
        .alarm_oe(alarm_oe)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            overheat_alarm_n_out <= 1'b0;
            overheat_alarm_n_oe <= 1'b0;
            setup_out <= RST_SETUP;
            sda_out <= 1'b0;
        end else begin
            overheat_alarm_n_out <= 1'b0;
            overheat_alarm_n_oe <= alarm_oe;
            setup_out <= setup_byte_reg;
            sda_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------------
    // Bits are taken on the rising clock edge and our own drive changes
    // only on the falling edge, so data is stable while the clock is high.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= BIT_CNT_ZERO;
            shift_reg <= RD_UNMAPPED;
            pointer_reg <= OFS_REMOTE_TEMP;
            rw_reg <= 1'b0;
            nack_reg <= 1'b1;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (bus_start) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= BIT_CNT_ZERO;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                    bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
                end
                ST_RDATA_ACK: nack_reg <= sda_s;
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (bit_cnt_reg == BYTE_BITS) begin
                        if (shift_reg[7:1] == DEV_ADDR) begin
                            state_reg <= ST_ADDR_ACK;
                            rw_reg <= shift_reg[0];
                            sda_oe <= 1'b1;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt_reg <= BIT_CNT_ZERO;
                    if (rw_reg) begin
                        state_reg <= ST_RDATA;
                        shift_reg <= rd_data;
                        sda_oe <= !rd_data[7];
                    end else begin
                        state_reg <= ST_CMD;
                        sda_oe <= 1'b0;
                    end
                end
                ST_CMD: begin
                    if (bit_cnt_reg == BYTE_BITS) begin
                        pointer_reg <= shift_reg;
                        state_reg <= ST_CMD_ACK;
                        sda_oe <= 1'b1;
                    end
                end
                ST_CMD_ACK: begin
                    state_reg <= ST_WDATA;
                    bit_cnt_reg <= BIT_CNT_ZERO;
                    sda_oe <= 1'b0;
                end
                ST_WDATA: begin
                    if (bit_cnt_reg == BYTE_BITS) begin
                        state_reg <= ST_WDATA_ACK;
                        sda_oe <= 1'b1;
                    end
                end
                ST_WDATA_ACK: begin
                    // Only one data byte per write; later bytes are not
                    // acknowledged.
                    state_reg <= ST_IGNORE;
                    sda_oe <= 1'b0;
                end
                ST_RDATA: begin
                    if (bit_cnt_reg == BIT_LAST_OUT) begin
                        state_reg <= ST_RDATA_ACK;
                        sda_oe <= 1'b0;
                    end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe <= !shift_reg[6];
                    end
                    bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
                end
                ST_RDATA_ACK: begin
                    bit_cnt_reg <= BIT_CNT_ZERO;
                    if (nack_reg) begin
                        state_reg <= ST_IGNORE;
                    end else begin
                        state_reg <= ST_RDATA;
                        shift_reg <= rd_data;
                        sda_oe <= !rd_data[7];
                    end
                end
                ST_IDLE, ST_IGNORE: sda_oe <= 1'b0;
                default: begin
                    state_reg <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_pointer_load: assert property (@(posedge clk)
        disable iff (!resetn)
        state_reg == ST_CMD && scl_fall && !bus_start && !bus_stop
        && bit_cnt_reg == BYTE_BITS
        |=> pointer_reg == $past(shift_reg) && sda_oe)
        else $error("Command byte did not load the pointer with an ack.");

    chk_addr_reject: assert property (@(posedge clk)
        disable iff (!resetn)
        state_reg == ST_ADDR && scl_fall && !bus_start && !bus_stop
        && bit_cnt_reg == BYTE_BITS && shift_reg[7:1] != DEV_ADDR
        |=> state_reg == ST_IGNORE && !sda_oe)
        else $error("Foreign address was acknowledged.");

    chk_msb_first: assert property (@(posedge clk)
        disable iff (!resetn)
        state_reg == ST_RDATA && scl_fall && !bus_start && !bus_stop
        && bit_cnt_reg != BIT_LAST_OUT
        |=> sda_oe == !$past(shift_reg[6]))
        else $error("Read byte not shifted out MSB first.");

    chk_read_mux: assert property (@(posedge clk)
        disable iff (!resetn)
        load_rd && !bus_start && !bus_stop
        && pointer_reg == OFS_REMOTE_TEMP
        |=> shift_reg == $past(remote_temp_reading_reg))
        else $error("Command 00h did not return the remote reading.");

    chk_reset_values: assert property (@(posedge clk)
        disable iff (!resetn)
        $rose(resetn) |-> remote_temp_reading_reg == RST_TEMP
        && local_temp_reading_reg == RST_TEMP
        && setup_byte_reg == RST_SETUP
        && remote_alarm_limit_reg == RST_REMOTE_LIMIT
        && local_alarm_limit_reg == RST_LOCAL_LIMIT
        && alarm_flags == RST_FLAGS)
        else $error("Register bank reset values wrong.");

    // The data byte is acknowledged for a whole bit time, so the ack is
    // checked at the first edge after the store, not its release.
    chk_limit_write: assert property (@(posedge clk)
        disable iff (!resetn)
        wr_en && !bus_start && !bus_stop
        && pointer_reg == OFS_REMOTE_LIMIT
        |=> remote_alarm_limit_reg == $past(shift_reg) && sda_oe)
        else $error("Write byte not stored in the remote limit or not acked.");

    chk_alarm_pin: assert property (@(posedge clk)
        disable iff (!resetn)
        status_read && !meas_done |=> ##1 !overheat_alarm_n_oe)
        else $error("Flag read did not release the alarm pin.");

endmodule

/* File: tarp_host.sv */
/*
 * Bus host model: frames write, read, send and receive byte transfers
 * on the two-wire port, one bit per 200 ns of link clock.
 * Assumes pull-ups on both lines and that clk is the device clock.
 */
`timescale 1ns/10ps
module tarp_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // The link clock stands high between frames and the data line is
    // released there, so the pull-up shows.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic q(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Data changes only mid-low; it is sampled late in the high phase,
    // well after the device's synchronised drive has settled.
    task automatic bit_io(input logic b, output logic r);
        q(2);
        sda_low = !b;
        q(2);
        scl = 1'b1;
        q(4);
        r = sda;
        scl = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic start();
        q(2);
        sda_low = 1'b0;
        q(2);
        scl = 1'b1;
        q(4);
        sda_low = 1'b1;
        q(4);
        scl = 1'b0;
    endtask

    task automatic stop();
        q(2);
        sda_low = 1'b1;
        q(2);
        scl = 1'b1;
        q(4);
        sda_low = 1'b0;
        q(4);
    endtask

    // Kind 0 write byte, 1 read byte, 2 send byte, 3 receive byte.
    // The host never acknowledges the byte it reads.
    task automatic access(input logic [6:0] a, input int kind,
                          input logic [7:0] cmd, input logic [7:0] wd,
                          output logic [7:0] rd, output logic ok);
        logic [7:0] junk;
        logic k;
        rd = 8'h00;
        start();
        xfer({a, kind == 3}, junk, ok);
        if (kind != 3) begin
            xfer(cmd, junk, k);
            ok = ok & k;
        end
        if (kind == 0) begin
            xfer(wd, junk, k);
            ok = ok & k;
        end
        if (kind == 1) begin
            start();
            xfer({a, 1'b1}, junk, k);
            ok = ok & k;
        end
        if (kind == 1 || kind == 3) begin
            xfer(8'hFF, rd, k);
        end
        stop();
    endtask
endmodule

/* File: tb_top.sv */
/*
 * Self-checking bench for the thermal alarm register port.
 * Assumes tarp_host as bus master and pull-ups on data and alarm pins.
 */
`timescale 1ns/10ps
module tb_top
    import tarp_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic meas_done = 1'b0;
    logic [7:0] remote_meas = 8'h00;
    logic [7:0] local_meas = 8'h00;
    logic scl, sda_low, sda_out, sda_oe, al_out, al_oe;
    logic [7:0] setup_out;
    int errors = 0;
    int checked = 0;
    wire sda = !(sda_low || (sda_oe && !sda_out));
    wire alarm_pin = !(al_oe && !al_out);

    always #12.5 clk = !clk;

    tarp_top dut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .meas_done(meas_done),
        .remote_meas(remote_meas), .local_meas(local_meas),
        .overheat_alarm_n_out(al_out), .overheat_alarm_n_oe(al_oe),
        .setup_out(setup_out));
    tarp_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic acc(input int kind, input logic [7:0] cmd,
                       input logic [7:0] wd, output logic [7:0] d);
        logic ok;
        host.access(DEV_ADDR_DEFAULT, kind, cmd, wd, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] wd);
        logic [7:0] d;
        acc(0, cmd, wd, d);
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        acc(1, cmd, 8'h00, d);
        chk(d, exp);
    endtask

    task automatic meas(input logic [7:0] r, input logic [7:0] l);
        remote_meas = r;
        local_meas = l;
        meas_done = 1'b1;
        @(posedge clk);
        #1;
        meas_done = 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic pin(input logic exp);
        chk({7'h00, alarm_pin}, {7'h00, exp});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h00, 8'h6E, 8'h50,
                                8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            rd_chk(8'(i), exp[i]);
        end
        chk(setup_out, 8'h00);
        pin(1'b1);
    endtask

    task automatic t_write();
        logic [7:0] d;
        logic ok;
        wr(8'h02, 8'hA5);
        rd_chk(8'h02, 8'hA5);
        chk(setup_out, 8'hA5);
        wr(8'h00, 8'h55);
        rd_chk(8'h00, 8'h00);
        host.access(DEV_ADDR_DEFAULT ^ 7'h01, 0, 8'h02, 8'h3C, d, ok);
        chk({7'h00, ok}, 8'h00);
        rd_chk(8'h02, 8'hA5);
    endtask

    task automatic t_meas();
        logic [7:0] d;
        meas(8'h6E, 8'h41);
        rd_chk(8'h00, 8'h6E);
        rd_chk(8'h01, 8'h41);
        pin(1'b1);
        rd_chk(8'h05, 8'h00);
        acc(2, 8'h00, 8'h00, d);
        acc(3, 8'h00, 8'h00, d);
        chk(d, 8'h6E);
    endtask

    task automatic t_alarm();
        meas(8'h6F, 8'h51);
        pin(1'b0);
        wr(8'h05, 8'h00);
        pin(1'b0);
        rd_chk(8'h05, 8'hC0);
        pin(1'b1);
        rd_chk(8'h00, 8'h6F);
        rd_chk(8'h05, 8'h00);
        meas(8'h6F, 8'h10);
        pin(1'b0);
        rd_chk(8'h05, 8'h80);
        wr(8'h06, 8'h80);
        meas(8'h6F, 8'h10);
        pin(1'b1);
        rd_chk(8'h05, 8'h80);
        meas(8'h10, 8'h51);
        pin(1'b0);
        rd_chk(8'h05, 8'h40);
        wr(8'h06, 8'h40);
        wr(8'h03, 8'h20);
        meas(8'h21, 8'h51);
        pin(1'b0);
        rd_chk(8'h05, 8'hC0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_write();
        t_meas();
        t_alarm();
        give_verdict();
    end

    initial begin
        #2000000;
        errors++;
        give_verdict();
    end
endmodule
